// *** core/psd_pkg.sv ***
package psd_pkg;
  // Register byte offsets on the APB side
  localparam logic [7:0] PSD_CMD_OFF = 8'h00;
  localparam logic [7:0] PSD_CARRY_OFF = 8'h04;
  localparam logic [7:0] PSD_SUM_OFF = 8'h08;
  localparam logic [7:0] PSD_ACT_OFF = 8'h0C;
  localparam logic [7:0] PSD_BCAST_OFF = 8'h10;
  localparam logic [7:0] PSD_MODIF_OFF = 8'h14;
  localparam logic [7:0] PSD_ITER_OFF = 8'h18;
  localparam logic [7:0] PSD_BLOCK_OFF = 8'h1C;
  localparam logic [7:0] PSD_STAT_OFF = 8'h20;
  localparam logic [7:0] PSD_SSEL_OFF = 8'h24;
  localparam logic [7:0] PSD_SDATA_OFF = 8'h28;
  // Command word field positions
  localparam int PSD_OP_LSB = 0;
  localparam int PSD_INV_BIT = 5;
  localparam int PSD_STEP_LSB = 6;
  localparam int PSD_ADDR_LSB = 8;
  localparam int PSD_DIR_LSB = 16;
  localparam int PSD_GEOM_LSB = 19;
  localparam int PSD_CNT_LSB = 21;
  // Modifier word field positions
  localparam int PSD_MADDR_LSB = 0;
  localparam int PSD_MINT_LSB = 8;
  // Status bit and block limit fields
  localparam int PSD_ERR_BIT = 0;
  localparam int PSD_LO_LSB = 0;
  localparam int PSD_HI_LSB = 8;
  // Values after reset
  localparam logic [7:0] PSD_LO_RST = 8'h00;
  localparam logic [7:0] PSD_HI_RST = 8'hFF;
  // Operations on the sum plane
  typedef enum logic [4:0] {
    PSD_OP_NULL = 5'h00,
    PSD_OP_CQA = 5'h01,
    PSD_OP_CQR = 5'h02,
    PSD_OP_CQRO = 5'h03,
    PSD_OP_CQS = 5'h04,
    PSD_OP_CQT = 5'h05,
    PSD_OP_CR = 5'h06,
    PSD_OP_CRO = 5'h07,
    PSD_OP_CS = 5'h08,
    PSD_OP_QA = 5'h09,
    PSD_OP_SUM_ROW = 5'h0A,
    PSD_OP_SUM_COL = 5'h0B,
    PSD_OP_QS = 5'h0C,
    PSD_OP_SHIFT = 5'h0D,
    PSD_OP_INV = 5'h0E,
    PSD_OP_COPYR = 5'h0F,
    PSD_OP_COPYC = 5'h10
  } psd_op_type;
  // Loop stepping of the store address
  typedef enum logic [1:0] {
    PSD_STEP_NONE = 2'h0,
    PSD_STEP_INC = 2'h1,
    PSD_STEP_DEC = 2'h2
  } psd_step_type;
  // Shift directions: compass then four raster codes
  typedef enum logic [2:0] {
    PSD_DIR_N = 3'h0,
    PSD_DIR_E = 3'h1,
    PSD_DIR_S = 3'h2,
    PSD_DIR_W = 3'h3,
    PSD_DIR_R0 = 3'h4,
    PSD_DIR_R1 = 3'h5,
    PSD_DIR_R2 = 3'h6,
    PSD_DIR_R3 = 3'h7
  } psd_dir_type;
  // Shift geometry
  typedef enum logic [1:0] {
    PSD_GEOM_P = 2'h0,
    PSD_GEOM_C = 2'h1,
    PSD_GEOM_PC = 2'h2,
    PSD_GEOM_CP = 2'h3
  } psd_geom_type;
endpackage

// *** core/psd_plane_sum_datapath.sv ***
// Our own choices: the APB interface to the registers and the register addresses.
`timescale 1ns/1ps
module psd_plane_sum_datapath import psd_pkg::*; #(
  parameter int EDGE_SIZE = 4,
  parameter int NPLANE = 16
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic run_error
);
  localparam int PW = EDGE_SIZE * EDGE_SIZE; // Bits in one plane
  localparam int SW = $clog2(NPLANE); // Store index width

  logic [PW-1:0] c_r; // Carry plane
  logic [PW-1:0] q_r; // Sum plane
  logic [PW-1:0] a_r; // Activity plane
  logic [EDGE_SIZE-1:0] bcast_r; // Broadcast register value
  logic [15:0] modif_r; // Address and count modifier
  logic [7:0] iter_r; // Loop iteration number
  logic [15:0] block_r; // Program block store limits
  logic err_r; // Sticky run-time error
  logic [SW-1:0] ssel_r; // Store plane for bus access
  logic [PW-1:0] store_r [NPLANE]; // Store planes
  logic pready_r; // Access phase answer
  logic pslverr_r; // Unmapped address answer
  logic [31:0] prdata_r; // Registered read data
  logic [PW-1:0] q_nxt; // Sum plane after the operation
  logic err_hit; // Store address refused

  // Bus strobes
  logic acc; // Access phase, before answer
  logic wr; // Write takes effect at this edge
  logic exec; // Command write launches operation
  logic mapped; // Address decodes to a register
  assign acc = psel & penable & ~pready_r;
  assign wr = psel & penable & pready_r & pwrite;
  assign exec = wr & (paddr == PSD_CMD_OFF);

  // Command fields, live while the command write stands
  psd_op_type op;
  logic inv;
  psd_step_type step;
  logic [7:0] afield;
  psd_dir_type dir;
  psd_geom_type geom;
  logic [4:0] cnt;
  assign op = psd_op_type'(pwdata[PSD_OP_LSB +: 5]);
  assign inv = pwdata[PSD_INV_BIT];
  assign step = psd_step_type'(pwdata[PSD_STEP_LSB +: 2]);
  assign afield = pwdata[PSD_ADDR_LSB +: 8];
  assign dir = psd_dir_type'(pwdata[PSD_DIR_LSB +: 3]);
  assign geom = psd_geom_type'(pwdata[PSD_GEOM_LSB +: 2]);
  assign cnt = pwdata[PSD_CNT_LSB +: 5];

  // Broadcast planes, one bit per element
  logic [PW-1:0] row_pl; // Every row holds the value
  logic [PW-1:0] col_pl; // Every column holds the value
  logic [PW-1:0] inv_pl; // Inversion mask
  assign inv_pl = {PW{inv}};
  generate
    for (genvar i = 0; i < PW; i++) begin : g_bc
      // Bit c of the value lands in column c of each row
      assign row_pl[i] = bcast_r[i % EDGE_SIZE];
      // Bit r of the value lands in row r of each column
      assign col_pl[i] = bcast_r[i / EDGE_SIZE];
    end
  endgenerate

  // Effective store address: field plus modifier, stepped by loop
  logic [9:0] ea; // Ten bits so an underflow shows in bit 9
  always_comb begin
    ea = {2'b00, afield} + {2'b00, modif_r[PSD_MADDR_LSB +: 8]};
    if (step == PSD_STEP_INC) begin
      ea = ea + {2'b00, iter_r};
    end else if (step == PSD_STEP_DEC) begin
      ea = ea - {2'b00, iter_r};
    end
  end

  // Address check against block limits and the store size
  logic bad_addr;
  assign bad_addr = ea[9] | (ea[7:0] < block_r[PSD_LO_LSB +: 8]) |
                    (ea[7:0] > block_r[PSD_HI_LSB +: 8]) | ea[8] |
                    (ea[7:0] > 8'(NPLANE - 1));
  logic [PW-1:0] s_pl; // Addressed store plane, inversion applied
  assign s_pl = store_r[ea[SW-1:0]] ^ inv_pl;

  // Effective count: field plus modifier int field, modulo edge size
  logic [8:0] kraw;
  logic [4:0] k;
  assign kraw = {4'h0, cnt} + {1'b0, modif_r[PSD_MINT_LSB +: 8]};
  assign k = 5'(kraw % 9'(EDGE_SIZE));

  // Shift whole plane; vacated places fill with zero unless cyclic
  function automatic logic [PW-1:0] shift_plane(
    input logic [PW-1:0] p,
    input psd_dir_type d,
    input psd_geom_type g,
    input int n
  );
    logic [PW-1:0] res;
    int sr;
    int sc;
    int si;
    logic ns_cyc;
    logic ew_cyc;
    res = '0;
    ns_cyc = (g == PSD_GEOM_C) | (g == PSD_GEOM_CP);
    ew_cyc = (g == PSD_GEOM_C) | (g == PSD_GEOM_PC);
    for (int r = 0; r < EDGE_SIZE; r++) begin
      for (int c = 0; c < EDGE_SIZE; c++) begin
        sr = r;
        sc = c;
        si = r * EDGE_SIZE + c;
        case (d)
          PSD_DIR_N: sr = r + n;
          PSD_DIR_S: sr = r - n;
          PSD_DIR_E: sc = c - n;
          PSD_DIR_W: sc = c + n;
          PSD_DIR_R0, PSD_DIR_R1: si = si + n;
          default: si = si - n;
        endcase
        if (d[2]) begin
          // Raster codes treat the plane as one long vector
          if (d[0]) begin
            res[r * EDGE_SIZE + c] = p[((si % PW) + PW) % PW];
          end else if (si >= 0 && si < PW) begin
            res[r * EDGE_SIZE + c] = p[si];
          end
        end else begin
          if (ns_cyc) begin
            sr = ((sr % EDGE_SIZE) + EDGE_SIZE) % EDGE_SIZE;
          end
          if (ew_cyc) begin
            sc = ((sc % EDGE_SIZE) + EDGE_SIZE) % EDGE_SIZE;
          end
          if (sr >= 0 && sr < EDGE_SIZE && sc >= 0 && sc < EDGE_SIZE) begin
            res[r * EDGE_SIZE + c] = p[sr * EDGE_SIZE + sc];
          end
        end
      end
    end
    return res;
  endfunction

  // Next sum plane; whole plane computed from old values at once
  always_comb begin
    q_nxt = q_r;
    err_hit = 1'b0;
    case (op)
      PSD_OP_CQA: q_nxt = c_r ^ q_r ^ a_r ^ inv_pl;
      PSD_OP_CQR: q_nxt = c_r ^ q_r ^ row_pl ^ inv_pl;
      PSD_OP_CQRO: q_nxt = c_r ^ q_r ^ col_pl ^ inv_pl;
      PSD_OP_CQT: q_nxt = ~(c_r ^ q_r);
      PSD_OP_CR: q_nxt = c_r ^ row_pl ^ inv_pl;
      PSD_OP_CRO: q_nxt = c_r ^ col_pl ^ inv_pl;
      PSD_OP_QA: q_nxt = q_r ^ a_r ^ inv_pl;
      PSD_OP_SUM_ROW: q_nxt = q_r ^ row_pl ^ inv_pl;
      PSD_OP_SUM_COL: q_nxt = q_r ^ col_pl ^ inv_pl;
      PSD_OP_CQS, PSD_OP_CS, PSD_OP_QS: begin
        // Refused address leaves the sum plane as it was
        if (bad_addr) begin
          err_hit = 1'b1;
        end else if (op == PSD_OP_CQS) begin
          q_nxt = c_r ^ q_r ^ s_pl;
        end else if (op == PSD_OP_CS) begin
          q_nxt = c_r ^ s_pl;
        end else begin
          q_nxt = q_r ^ s_pl;
        end
      end
      PSD_OP_SHIFT: begin
        // Zero count is a no-op
        if (k != 5'h00) begin
          q_nxt = shift_plane(q_r, dir, geom, int'(k));
        end
      end
      PSD_OP_INV: q_nxt = ~q_r;
      PSD_OP_COPYR: q_nxt = row_pl ^ inv_pl;
      PSD_OP_COPYC: q_nxt = col_pl ^ inv_pl;
      default: q_nxt = q_r;
    endcase
  end

  // Sum plane: one edge updates every element together
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q_r <= '0;
    end else if (exec) begin
      q_r <= q_nxt;
    end else if (wr && paddr == PSD_SUM_OFF) begin
      q_r <= pwdata[PW-1:0];
    end
  end

  // Carry plane: only software writes it, operations never do
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      c_r <= '0;
    end else if (wr && paddr == PSD_CARRY_OFF) begin
      c_r <= pwdata[PW-1:0];
    end
  end

  // Operand registers written by the controller
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      a_r <= '0;
      bcast_r <= '0;
      modif_r <= '0;
      iter_r <= '0;
      block_r <= {PSD_HI_RST, PSD_LO_RST};
      ssel_r <= '0;
    end else if (wr) begin
      if (paddr == PSD_ACT_OFF) begin
        a_r <= pwdata[PW-1:0];
      end else if (paddr == PSD_BCAST_OFF) begin
        // Selected register value, zero-extended by the controller
        bcast_r <= pwdata[EDGE_SIZE-1:0];
      end else if (paddr == PSD_MODIF_OFF) begin
        modif_r <= pwdata[15:0];
      end else if (paddr == PSD_ITER_OFF) begin
        iter_r <= pwdata[7:0];
      end else if (paddr == PSD_BLOCK_OFF) begin
        block_r <= pwdata[15:0];
      end else if (paddr == PSD_SSEL_OFF) begin
        ssel_r <= pwdata[SW-1:0];
      end
    end
  end

  // Store planes: loaded by software through the select window
  always_ff @(posedge pclk) begin
    if (wr && paddr == PSD_SDATA_OFF) begin
      store_r[ssel_r] <= pwdata[PW-1:0];
    end
  end

  // Sticky error; a new error wins over a clear in the same edge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      err_r <= 1'b0;
    end else if (exec && err_hit) begin
      err_r <= 1'b1;
    end else if (wr && paddr == PSD_STAT_OFF && pwdata[PSD_ERR_BIT]) begin
      err_r <= 1'b0;
    end
  end

  // Address decode
  always_comb begin
    if (paddr == PSD_CMD_OFF || paddr == PSD_CARRY_OFF) begin
      mapped = 1'b1;
    end else if (paddr == PSD_SUM_OFF || paddr == PSD_ACT_OFF) begin
      mapped = 1'b1;
    end else if (paddr == PSD_BCAST_OFF || paddr == PSD_MODIF_OFF) begin
      mapped = 1'b1;
    end else if (paddr == PSD_ITER_OFF || paddr == PSD_BLOCK_OFF) begin
      mapped = 1'b1;
    end else if (paddr == PSD_STAT_OFF || paddr == PSD_SSEL_OFF) begin
      mapped = 1'b1;
    end else begin
      mapped = (paddr == PSD_SDATA_OFF);
    end
  end

  // One wait state: answer in the second access cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
    end else begin
      pready_r <= acc;
      pslverr_r <= acc & ~mapped;
    end
  end

  // Read data captured with the answer; command reads as zero
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_r <= '0;
    end else if (acc && !pwrite) begin
      if (paddr == PSD_CARRY_OFF) begin
        prdata_r <= 32'(c_r);
      end else if (paddr == PSD_SUM_OFF) begin
        prdata_r <= 32'(q_r);
      end else if (paddr == PSD_ACT_OFF) begin
        prdata_r <= 32'(a_r);
      end else if (paddr == PSD_BCAST_OFF) begin
        prdata_r <= 32'(bcast_r);
      end else if (paddr == PSD_MODIF_OFF) begin
        prdata_r <= 32'(modif_r);
      end else if (paddr == PSD_ITER_OFF) begin
        prdata_r <= 32'(iter_r);
      end else if (paddr == PSD_BLOCK_OFF) begin
        prdata_r <= 32'(block_r);
      end else if (paddr == PSD_STAT_OFF) begin
        prdata_r <= 32'(err_r);
      end else if (paddr == PSD_SSEL_OFF) begin
        prdata_r <= 32'(ssel_r);
      end else if (paddr == PSD_SDATA_OFF) begin
        prdata_r <= 32'(store_r[ssel_r]);
      end else begin
        prdata_r <= '0;
      end
    end
  end

  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;
  assign run_error = err_r;

  // Checks on the plane operations
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  acc_act_a: assert property (exec && op == PSD_OP_CQA |=>
    q_r == ($past(c_r) ^ $past(q_r) ^ $past(a_r) ^ {PW{$past(inv)}}))
    else $error("carry sum activity result wrong");
  carry_hold_a: assert property (exec |=> $stable(c_r))
    else $error("carry plane changed by an operation");
  acc_row_a: assert property (exec && op == PSD_OP_CQR |=>
    q_r == ($past(c_r) ^ $past(q_r) ^ $past(row_pl) ^ {PW{$past(inv)}}))
    else $error("row broadcast sum wrong");
  ones_sum_a: assert property (exec && op == PSD_OP_CQT |=>
    q_r == ~($past(c_r) ^ $past(q_r)))
    else $error("all ones sum wrong");
  store_err_a: assert property (exec && err_hit |=>
    err_r && $stable(q_r) && run_error)
    else $error("bad store address not flagged");
  shift_zero_a: assert property (exec && op == PSD_OP_SHIFT && k == 5'h00
    |=> $stable(q_r))
    else $error("zero shift changed sum plane");
  invert_all_a: assert property (exec && op == PSD_OP_INV |=> q_r == ~$past(q_r))
    else $error("invert result wrong");
  copy_col_a: assert property (exec && op == PSD_OP_COPYC |=>
    q_r == ($past(col_pl) ^ {PW{$past(inv)}}))
    else $error("column copy wrong");
  dec_step_a: assert property (step == PSD_STEP_DEC && psel
    |-> ea == ({2'b00, afield} + {2'b00, modif_r[7:0]} - {2'b00, iter_r}))
    else $error("decrement step address wrong");
endmodule // psd_plane_sum_datapath

// *** bench/psd_ctl_model.sv ***
`timescale 1ns/1ps
// Controller side of the datapath: issues commands and operands over APB
module psd_ctl_model (
  input wire logic pclk,
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [7:0] paddr,
  output logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr
);
  // Bus idle at time zero
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
  end

  // One transfer; waits on pready with no assumed latency
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] rd, output logic err);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // Request held until the completing edge
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // Released data inverted so a stale word is never mistaken for a live one
    pwdata <= ~d;
  endtask
endmodule // psd_ctl_model

// *** bench/psd_plane_sum_datapath_bench.sv ***
`timescale 1ns/1ps
module psd_plane_sum_datapath_bench import psd_pkg::*; ;
  logic pclk;
  logic presetn;
  logic psel;
  logic penable;
  logic pwrite;
  logic [7:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic run_error;
  int miscompares = 0;
  int check_count = 0;
  // Operand planes; edge size 4, bit i is row i/4, column i%4
  localparam logic [15:0] C_V = 16'hA5C3;
  localparam logic [15:0] A_V = 16'h1234;
  localparam logic [15:0] Q_V = 16'h3C96;
  localparam logic [15:0] S_V = 16'h5A69;
  localparam logic [3:0] BC_V = 4'hB;
  // Broadcast value B: every row 1011, rows 0, 1 and 3 all ones
  localparam logic [15:0] ROW_V = 16'hBBBB;
  localparam logic [15:0] COL_V = 16'hF0FF;

  psd_plane_sum_datapath psd_plane_sum_datapath_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .run_error(run_error));
  psd_ctl_model psd_ctl_model_inst (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));

  // Free-running 125 MHz clock
  initial begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end

  // Closing task shared by the main sequence and the watchdog
  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  // Single comparison point, four-state exact
  task automatic check(string name, logic [31:0] seen, logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic wr(logic [7:0] a, logic [31:0] d);
    logic [31:0] rd;
    logic e;
    psd_ctl_model_inst.xfer(1'b1, a, d, rd, e);
  endtask

  // Read and compare data and error flag
  task automatic rd_chk(string name, logic [7:0] a, logic [31:0] exp, logic exp_err);
    logic [31:0] rd;
    logic e;
    psd_ctl_model_inst.xfer(1'b0, a, 32'h0000_0000, rd, e);
    check(name, rd, exp);
    check({name, " slverr"}, {31'h0, e}, {31'h0, exp_err});
  endtask

  function automatic logic [31:0] cmd_word(logic [4:0] op, logic inv, logic [1:0] step,
      logic [7:0] addr, logic [2:0] dir, logic [1:0] geom, logic [4:0] cnt);
    return {6'h00, cnt, geom, dir, addr, step, inv, op};
  endfunction

  // Load Q, run one command, read the whole plane back
  task automatic run_op(string name, logic [31:0] cmd, logic [15:0] exp);
    wr(PSD_SUM_OFF, {16'h0, Q_V});
    wr(PSD_CMD_OFF, cmd);
    rd_chk(name, PSD_SUM_OFF, {16'h0, exp}, 1'b0);
  endtask

  // Expected sum plane from the operation table
  function automatic logic [15:0] exp_q(int op, logic inv);
    logic [15:0] t;
    case (op)
      1, 9: t = A_V;
      2, 6, 10, 15: t = ROW_V;
      3, 7, 11, 16: t = COL_V;
      4, 8, 12: t = S_V;
      default: t = 16'h0000;
    endcase
    if (inv) t = ~t;
    case (op)
      1, 2, 3, 4: return C_V ^ Q_V ^ t;
      5: return ~(C_V ^ Q_V);
      6, 7, 8: return C_V ^ t;
      9, 10, 11, 12: return Q_V ^ t;
      14: return ~Q_V;
      default: return t;
    endcase
  endfunction

  // Reset values and an unmapped address
  task automatic t_reset();
    rd_chk("limits", PSD_BLOCK_OFF, 32'h0000_FF00, 1'b0);
    rd_chk("status", PSD_STAT_OFF, 32'h0000_0000, 1'b0);
    rd_chk("unmapped", 8'h30, 32'h0000_0000, 1'b1);
  endtask

  // Every plane operation except shift, plain and, where it has an inverted form, inverted
  task automatic t_ops();
    wr(PSD_CARRY_OFF, {16'h0, C_V});
    wr(PSD_ACT_OFF, {16'h0, A_V});
    wr(PSD_BCAST_OFF, {28'h0, BC_V});
    wr(PSD_SSEL_OFF, 32'h0000_0005);
    wr(PSD_SDATA_OFF, {16'h0, S_V});
    wr(PSD_MODIF_OFF, 32'h0000_0000);
    wr(PSD_ITER_OFF, 32'h0000_0000);
    for (int op = 1; op <= 16; op++) begin
      for (int inv = 0; inv < 2; inv++) begin
        // Shift has its own scenario; ones and invert have no inverted form
        if (op == 13 || (inv == 1 && (op == 5 || op == 14))) continue;
        run_op($sformatf("op %0d inv %0d", op, inv), cmd_word(op[4:0], inv[0], 2'h0, 8'h05, 3'h0, 2'h0,
          5'h00), exp_q(op, inv[0]));
      end
    end
    rd_chk("carry kept", PSD_CARRY_OFF, {16'h0, C_V}, 1'b0);
  endtask

  // Raster shifts both fills, and zero effective counts
  task automatic t_shift();
    run_op("r1 by 1", cmd_word(5'h0D, 1'b0, 2'h0, 8'h00, 3'h5, 2'h0, 5'h01), {Q_V[0], Q_V[15:1]});
    run_op("r0 by 2", cmd_word(5'h0D, 1'b0, 2'h0, 8'h00, 3'h4, 2'h0, 5'h02), {2'b00, Q_V[15:2]});
    run_op("r2 by 1", cmd_word(5'h0D, 1'b0, 2'h0, 8'h00, 3'h6, 2'h0, 5'h01), {Q_V[14:0], 1'b0});
    run_op("r3 by 3", cmd_word(5'h0D, 1'b0, 2'h0, 8'h00, 3'h7, 2'h0, 5'h03), {Q_V[12:0], Q_V[15:13]});
    // Compass moves: east in plane geometry fills column 0 with zero
    run_op("e p by 1", cmd_word(5'h0D, 1'b0, 2'h0, 8'h00, 3'h1, 2'h0, 5'h01), (Q_V << 1) & 16'hEEEE);
    // North in cyclic geometry: row r takes row r+1, top wraps
    run_op("n c by 1", cmd_word(5'h0D, 1'b0, 2'h0, 8'h00, 3'h0, 2'h1, 5'h01), {Q_V[3:0], Q_V[15:4]});
    run_op("count 0", cmd_word(5'h0D, 1'b0, 2'h0, 8'h00, 3'h1, 2'h1, 5'h00), Q_V);
    // Count 3 plus modifier 1 wraps to zero for edge size 4
    wr(PSD_MODIF_OFF, 32'h0000_0100);
    run_op("count 3+1", cmd_word(5'h0D, 1'b0, 2'h0, 8'h00, 3'h1, 2'h0, 5'h03), Q_V);
  endtask

  // Modified, loop-stepped store address; then out of block
  task automatic t_store();
    logic [31:0] c;
    c = cmd_word(5'h0C, 1'b0, 2'h2, 8'h0A, 3'h0, 2'h0, 5'h00);
    wr(PSD_SSEL_OFF, 32'h0000_0009);
    wr(PSD_SDATA_OFF, 32'h0000_0F0F);
    // Address field 1, count field 3 which must not matter
    wr(PSD_MODIF_OFF, 32'h0000_0301);
    wr(PSD_ITER_OFF, 32'h0000_0002);
    run_op("store 10+1-2", c, Q_V ^ 16'h0F0F);
    check("no error", {31'h0, run_error}, 32'h0000_0000);
    // Plane 9 now lies above the block
    wr(PSD_BLOCK_OFF, 32'h0000_0800);
    run_op("store refused", c, Q_V);
    check("error flag", {31'h0, run_error}, 32'h0000_0001);
    rd_chk("status set", PSD_STAT_OFF, 32'h0000_0001, 1'b0);
    wr(PSD_STAT_OFF, 32'h0000_0001);
    // Clear lands at the completing edge; look one edge later
    @(posedge pclk);
    check("error cleared", {31'h0, run_error}, 32'h0000_0000);
    wr(PSD_BLOCK_OFF, 32'h0000_FF00);
  endtask

  // Main sequence
  initial begin
    presetn = 1'b0;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_ops();
    t_shift();
    t_store();
    give_verdict();
  end

  // Watchdog: whole run needs well under a thousand cycles
  initial begin
    repeat (5000) @(posedge pclk);
    miscompares++;
    give_verdict();
  end
endmodule // psd_plane_sum_datapath_bench
